// ---- pkg/drdt_map.svh ----
// Purpose: Register indices, field positions, reset values and counts of the dual reload down timer
// Assumes: Byte address of a register is four times its index
// Notes:   Definitions only
`ifndef DRDT_MAP_SVH
`define DRDT_MAP_SVH

// Register indices; byte address is index times four
`define DRDT_IX_EVCFG   16'hffc0
`define DRDT_IX_OUTSEL  16'hffc1
`define DRDT_IX_CTRL0   16'hffc2
`define DRDT_IX_CTRL1   16'hffc3
`define DRDT_IX_RLD0_LO 16'hffc4
`define DRDT_IX_RLD0_HI 16'hffc5
`define DRDT_IX_RLD1_LO 16'hffc6
`define DRDT_IX_RLD1_HI 16'hffc7
`define DRDT_IX_CNT0_LO 16'hffc8
`define DRDT_IX_CNT0_HI 16'hffc9
`define DRDT_IX_CNT1_LO 16'hffca
`define DRDT_IX_CNT1_HI 16'hffcb
`define DRDT_IX_MASK    16'hffe2
`define DRDT_IX_FLAGS   16'hfff2

// Field positions
`define DRDT_B_EVMODE   2
`define DRDT_B_NREN     1
`define DRDT_B_EDGE     0
`define DRDT_B_TOGGLE_SOURCE_SEL    3
`define DRDT_B_TOUTEN   2
`define DRDT_B_SRC1     1
`define DRDT_B_SRC0     0
`define DRDT_B_DIVHI    3
`define DRDT_B_DIVLO    2
`define DRDT_B_PRESET   1
`define DRDT_B_RUN      0

// Reset values
`define DRDT_RST_NIB    4'h0
`define DRDT_RST_BYTE   8'h00

// Prescaler masks for divide by 1, 4, 32 and 256
`define DRDT_MASK_DIV1   8'h00
`define DRDT_MASK_DIV4   8'h03
`define DRDT_MASK_DIV32  8'h1f
`define DRDT_MASK_DIV256 8'hff

// Noise rejecter: slow osc / 16 gives the 2048 Hz strobe, level taken on 2nd edge
`define DRDT_NR_DIV_LAST 4'hf
`define DRDT_NR_EDGES    2'h2

`endif

// ---- pkg/drdt_pkg.sv ----
// Purpose: Types of the dual reload down timer
// Assumes: Two counters, 4-bit register data
// Notes:   Whole state of the block is one packed struct
package drdt_pkg;

    // Complete register state of the timer block
    typedef struct packed {
        logic [1:0]      slow_s;    // Slow osc synchroniser, [0] first stage
        logic [1:0]      fast_s;    // Fast osc synchroniser
        logic [1:0]      evt_s;     // Event pin synchroniser
        logic            slow_p;    // Previous synced slow osc
        logic            fast_p;    // Previous synced fast osc
        logic            evt_p;     // Previous event level after filter
        logic [3:0]      nr_div;    // 2048 Hz strobe divider
        logic [1:0]      nr_cnt;    // Strobe edges seen since level change
        logic            nr_lvl;    // Accepted filtered level
        logic            ev_mode;
        logic            nr_en;
        logic            edge_sel;
        logic            toggle_source_sel;
        logic            toggle_out_en;
        logic [1:0]      src_sel;
        logic [1:0][1:0] div_sel;
        logic [1:0]      run_req;
        logic [1:0]      active;
        logic [1:0][7:0] psc;
        logic [1:0][7:0] reload;
        logic [1:0][7:0] count;
        logic [1:0][3:0] hold;      // High nibble latched by low read
        logic [1:0]      irq_en;
        logic [1:0]      flag;
        logic [1:0]      irq;
        logic            toggle;
        logic            sclk;
        logic            pin;
        logic            ack;
        logic [3:0]      dat;
    } drdt_state_type;

endpackage : drdt_pkg

// ---- hdl/drdt_timer.sv ----
// Purpose: Two 8-bit reloadable down counters with prescalers, event input, toggle output
// Assumes: clk at 25 MHz, oscillators and event pin asynchronous and much slower than clk
// Notes:   Registers reached over classic Wishbone, 4-bit data in the low bits
`timescale 1ns/1ps
`default_nettype none
`include "drdt_map.svh"

module drdt_timer
    import drdt_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [17:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        slow_osc,
    input  wire logic        fast_osc,
    input  wire logic        event_in_pin,
    output logic             shared_out_pin,
    output logic             toggle_out,
    output logic             serial_clk_out,
    output logic             irq_counter0,
    output logic             irq_counter1
);

    drdt_state_type st_q;
    drdt_state_type st_d;

    // Combinational helpers, also watched by the checks below
    logic        req;
    logic        wr;
    logic        rd;
    logic [15:0] idx;
    logic [3:0]  wdat;
    logic        slow_fall;
    logic        fast_fall;
    logic        nr_strobe;
    logic        lvl;
    logic        evt_tick;
    logic [1:0]  src_tick;
    logic [1:0]  in_tick;
    logic [1:0]  uf;
    logic [1:0]  preset_wr;
    logic [7:0]  mask;

    // Prescaler compare mask for a ratio field
    function automatic logic [7:0] div_mask(input logic [1:0] sel);
        case (sel)
            2'h0:    div_mask = `DRDT_MASK_DIV1;
            2'h1:    div_mask = `DRDT_MASK_DIV4;
            2'h2:    div_mask = `DRDT_MASK_DIV32;
            default: div_mask = `DRDT_MASK_DIV256;
        endcase
    endfunction : div_mask

    // Next-state logic for the whole block
    always_comb begin
        st_d      = st_q;
        mask      = `DRDT_MASK_DIV1;
        uf        = 2'h0;
        preset_wr = 2'h0;
        in_tick   = 2'h0;
        src_tick  = 2'h0;

        // Bus request decode; one access per ack, ack never held two cycles
        // A write with sel[0] low changes nothing but is still acknowledged
        req  = wb_cyc_i && wb_stb_i && !st_q.ack;
        wr   = req && wb_we_i && wb_sel_i[0];
        rd   = req && !wb_we_i;
        idx  = wb_adr_i[17:2];
        wdat = wb_dat_i[3:0];

        // Two-stage synchronisers; only stage 1 reads stage 0
        st_d.slow_s = {st_q.slow_s[0], slow_osc};
        st_d.fast_s = {st_q.fast_s[0], fast_osc};
        st_d.evt_s  = {st_q.evt_s[0], event_in_pin};
        st_d.slow_p = st_q.slow_s[1];
        st_d.fast_p = st_q.fast_s[1];
        // Counters step on the falling edge of their input clock
        slow_fall   = st_q.slow_p && !st_q.slow_s[1];
        fast_fall   = st_q.fast_p && !st_q.fast_s[1];

        // Noise rejecter: level must persist to second 2048 Hz falling edge
        // Strobe divider runs free, so the filter delay varies by one strobe period
        nr_strobe = slow_fall && (st_q.nr_div == `DRDT_NR_DIV_LAST);
        if (slow_fall) begin
            st_d.nr_div = st_q.nr_div + 4'h1;
        end
        if (st_q.evt_s[1] == st_q.nr_lvl) begin
            st_d.nr_cnt = 2'h0;
        end else if (nr_strobe) begin
            if (st_q.nr_cnt + 2'h1 == `DRDT_NR_EDGES) begin
                st_d.nr_lvl = st_q.evt_s[1];
                st_d.nr_cnt = 2'h0;
            end else begin
                st_d.nr_cnt = st_q.nr_cnt + 2'h1;
            end
        end
        lvl        = st_q.nr_en ? st_q.nr_lvl : st_q.evt_s[1];
        st_d.evt_p = lvl;
        // Edge polarity select for event counting
        evt_tick   = st_q.edge_sel ? (lvl && !st_q.evt_p) : (!lvl && st_q.evt_p);

        // Register writes
        if (wr) begin
            case (idx)
                `DRDT_IX_EVCFG: begin
                    st_d.ev_mode  = wdat[`DRDT_B_EVMODE];
                    st_d.nr_en    = wdat[`DRDT_B_NREN];
                    st_d.edge_sel = wdat[`DRDT_B_EDGE];
                end
                `DRDT_IX_OUTSEL: begin
                    st_d.toggle_source_sel      = wdat[`DRDT_B_TOGGLE_SOURCE_SEL];
                    st_d.toggle_out_en    = wdat[`DRDT_B_TOUTEN];
                    st_d.src_sel[1] = wdat[`DRDT_B_SRC1];
                    st_d.src_sel[0] = wdat[`DRDT_B_SRC0];
                end
                `DRDT_IX_CTRL0: begin
                    st_d.div_sel[0] = wdat[`DRDT_B_DIVHI:`DRDT_B_DIVLO];
                    st_d.run_req[0] = wdat[`DRDT_B_RUN];
                    preset_wr[0]    = wdat[`DRDT_B_PRESET];
                end
                `DRDT_IX_CTRL1: begin
                    st_d.div_sel[1] = wdat[`DRDT_B_DIVHI:`DRDT_B_DIVLO];
                    st_d.run_req[1] = wdat[`DRDT_B_RUN];
                    preset_wr[1]    = wdat[`DRDT_B_PRESET];
                end
                `DRDT_IX_RLD0_LO: st_d.reload[0][3:0] = wdat;
                `DRDT_IX_RLD0_HI: st_d.reload[0][7:4] = wdat;
                `DRDT_IX_RLD1_LO: st_d.reload[1][3:0] = wdat;
                `DRDT_IX_RLD1_HI: st_d.reload[1][7:4] = wdat;
                `DRDT_IX_MASK:    st_d.irq_en = wdat[1:0];
                default: begin
                    // Count registers and unmapped words ignore writes
                end
            endcase
        end

        // Per-counter prescaler, run control and down count
        for (int i = 0; i < 2; i++) begin
            src_tick[i] = st_q.src_sel[i] ? fast_fall : slow_fall;
            mask        = div_mask(st_q.div_sel[i]);
            // Prescaler idles at zero while the counter is fully stopped
            // A preset also restarts it, so the first tick is a full period away
            if (preset_wr[i] || !(st_q.run_req[i] || st_q.active[i])) begin
                st_d.psc[i] = `DRDT_RST_BYTE;
            end else if (src_tick[i]) begin
                st_d.psc[i] = st_q.psc[i] + 8'h01;
            end
            in_tick[i] = src_tick[i] && ((st_q.psc[i] & mask) == mask)
                         && (st_q.run_req[i] || st_q.active[i]);
            if (i == 0 && st_q.ev_mode) begin
                in_tick[i] = evt_tick;
            end
            if (in_tick[i]) begin
                // Run changes land on an input tick, after this decrement
                st_d.active[i] = st_q.run_req[i];
                if (st_q.active[i]) begin
                    if (st_q.count[i] == `DRDT_RST_BYTE) begin
                        uf[i]         = 1'b1;
                        st_d.count[i] = st_q.reload[i];
                    end else begin
                        st_d.count[i] = st_q.count[i] - 8'h01;
                    end
                end
            end
            if (preset_wr[i]) begin
                st_d.count[i] = st_q.reload[i];
            end
        end

        // Flags: underflow set wins over a write-one clear
        if (wr && idx == `DRDT_IX_FLAGS) begin
            st_d.flag = st_q.flag & ~wdat[1:0];
        end
        st_d.flag = st_d.flag | uf;
        st_d.irq  = st_d.flag & st_d.irq_en;

        // Toggle and serial clock, each halves its underflow rate
        if (st_q.toggle_source_sel ? uf[1] : uf[0]) begin
            st_d.toggle = !st_q.toggle;
        end
        if (uf[1] && st_q.active[1]) begin
            st_d.sclk = !st_q.sclk;
        end
        // Enable gates the toggle with no resync to its phase
        st_d.pin = st_q.toggle_out_en ? st_d.toggle : 1'b1;

        // Read data, returned with the ack one cycle later
        st_d.ack = req;
        if (rd) begin
            case (idx)
                `DRDT_IX_EVCFG:   st_d.dat = {1'b0, st_q.ev_mode, st_q.nr_en, st_q.edge_sel};
                `DRDT_IX_OUTSEL:  st_d.dat = {st_q.toggle_source_sel, st_q.toggle_out_en, st_q.src_sel};
                `DRDT_IX_CTRL0:   st_d.dat = {st_q.div_sel[0], 1'b0,
                                              st_q.run_req[0] || st_q.active[0]};
                `DRDT_IX_CTRL1:   st_d.dat = {st_q.div_sel[1], 1'b0,
                                              st_q.run_req[1] || st_q.active[1]};
                `DRDT_IX_RLD0_LO: st_d.dat = st_q.reload[0][3:0];
                `DRDT_IX_RLD0_HI: st_d.dat = st_q.reload[0][7:4];
                `DRDT_IX_RLD1_LO: st_d.dat = st_q.reload[1][3:0];
                `DRDT_IX_RLD1_HI: st_d.dat = st_q.reload[1][7:4];
                `DRDT_IX_CNT0_LO: begin
                    st_d.dat     = st_q.count[0][3:0];
                    st_d.hold[0] = st_q.count[0][7:4];
                end
                `DRDT_IX_CNT0_HI: st_d.dat = st_q.hold[0];
                `DRDT_IX_CNT1_LO: begin
                    st_d.dat     = st_q.count[1][3:0];
                    st_d.hold[1] = st_q.count[1][7:4];
                end
                `DRDT_IX_CNT1_HI: st_d.dat = st_q.hold[1];
                `DRDT_IX_MASK:    st_d.dat = {2'h0, st_q.irq_en};
                `DRDT_IX_FLAGS:   st_d.dat = {2'h0, st_q.flag};
                default:          st_d.dat = `DRDT_RST_NIB;
            endcase
        end
    end

    // State register; every field but pin clears at reset, pin idles high
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q     <= '0;
            st_q.pin <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from the state register
    assign wb_dat_o       = {28'h0000000, st_q.dat};
    assign wb_ack_o       = st_q.ack;
    assign shared_out_pin = st_q.pin;
    assign toggle_out     = st_q.toggle;
    assign serial_clk_out = st_q.sclk;
    assign irq_counter0   = st_q.irq[0];
    assign irq_counter1   = st_q.irq[1];

    // Checks on the bus handshake
    a_ack_single_pulse: assert property (@(posedge clk) disable iff (!arst_n)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_after_req: assert property (@(posedge clk) disable iff (!arst_n)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
        else $error("request not acknowledged next cycle");

    // Read data of partly used registers
    a_preset_reads_zero: assert property (@(posedge clk) disable iff (!arst_n)
        ($past(rd) && ($past(idx) == `DRDT_IX_CTRL0 || $past(idx) == `DRDT_IX_CTRL1)) |-> !wb_dat_o[`DRDT_B_PRESET])
        else $error("preset bit did not read 0");
    a_unused_read_zero: assert property (@(posedge clk) disable iff (!arst_n)
        ($past(rd) && ($past(idx) == `DRDT_IX_MASK || $past(idx) == `DRDT_IX_FLAGS)) |-> wb_dat_o[3:2] == 2'h0)
        else $error("unused bits did not read 0");

    // Count registers: read-only, high nibble latched by the low read
    a_count_readonly: assert property (@(posedge clk) disable iff (!arst_n)
        (wr && idx == `DRDT_IX_CNT0_LO && !in_tick[0]) |=> $stable(st_q.count[0]))
        else $error("write changed a count");
    a_hold_latch: assert property (@(posedge clk) disable iff (!arst_n)
        (rd && idx == `DRDT_IX_CNT0_LO) |=> st_q.hold[0] == $past(st_q.count[0][7:4]))
        else $error("high nibble not latched");
    a_high_from_hold: assert property (@(posedge clk) disable iff (!arst_n)
        ($past(rd) && $past(idx) == `DRDT_IX_CNT0_HI) |-> wb_dat_o[3:0] == $past(st_q.hold[0]))
        else $error("high read not the latched nibble");

    // Underflow reloads and sets its flag
    a_uf_reload: assert property (@(posedge clk) disable iff (!arst_n)
        (uf[0] && !preset_wr[0]) |=> st_q.count[0] == $past(st_q.reload[0]))
        else $error("counter 0 not reloaded on underflow");
    a_flag_set_wins: assert property (@(posedge clk) disable iff (!arst_n)
        uf[1] |=> st_q.flag[1])
        else $error("underflow flag lost");
    a_flag_clear: assert property (@(posedge clk) disable iff (!arst_n)
        (wr && idx == `DRDT_IX_FLAGS && wdat[0] && !uf[0]) |=> !st_q.flag[0])
        else $error("flag not cleared by write one");
    a_mask_write: assert property (@(posedge clk) disable iff (!arst_n)
        (wr && idx == `DRDT_IX_MASK) |=> st_q.irq_en == $past(wdat[1:0]))
        else $error("mask write not taken");
    a_irq_gated: assert property (@(posedge clk) disable iff (!arst_n)
        irq_counter0 == (st_q.flag[0] && st_q.irq_en[0]))
        else $error("interrupt request not flag and enable");

    // Preset, stop hold and run control
    a_preset_load: assert property (@(posedge clk) disable iff (!arst_n)
        preset_wr[1] |=> st_q.count[1] == $past(st_q.reload[1]))
        else $error("preset did not load reload value");
    a_stopped_holds: assert property (@(posedge clk) disable iff (!arst_n)
        (!st_q.active[0] && !preset_wr[0]) |=> $stable(st_q.count[0]))
        else $error("stopped counter changed");
    a_run_on_tick: assert property (@(posedge clk) disable iff (!arst_n)
        (!in_tick[1] && st_q.active[1] != st_q.run_req[1]) |=> st_q.active[1] == $past(st_q.active[1]))
        else $error("run state changed without an input tick");
    a_stop_decrement: assert property (@(posedge clk) disable iff (!arst_n)
        (in_tick[0] && st_q.active[0] && !st_q.run_req[0] && !uf[0] && !preset_wr[0])
        |=> (st_q.count[0] == $past(st_q.count[0]) - 8'h01) && !st_q.active[0])
        else $error("stop did not follow one decrement");
    a_run_reads_one: assert property (@(posedge clk) disable iff (!arst_n)
        (rd && idx == `DRDT_IX_CTRL0 && st_q.active[0]) |=> wb_dat_o[`DRDT_B_RUN])
        else $error("run bit read 0 while still running");

    // Event path of counter 0
    a_event_tick: assert property (@(posedge clk) disable iff (!arst_n)
        st_q.ev_mode |-> in_tick[0] == evt_tick)
        else $error("event mode tick not from event edge");
    a_mode_write: assert property (@(posedge clk) disable iff (!arst_n)
        (wr && idx == `DRDT_IX_EVCFG) |=> st_q.ev_mode == $past(wdat[`DRDT_B_EVMODE]))
        else $error("mode write not taken");
    a_nr_holds: assert property (@(posedge clk) disable iff (!arst_n)
        !nr_strobe |=> $stable(st_q.nr_lvl))
        else $error("filtered level changed off strobe");
    a_nr_bypass: assert property (@(posedge clk) disable iff (!arst_n)
        !st_q.nr_en |-> lvl == st_q.evt_s[1])
        else $error("event level not direct with rejecter off");

    // Prescaler source and ratio
    a_src_select: assert property (@(posedge clk) disable iff (!arst_n)
        in_tick[1] |-> (st_q.src_sel[1] ? fast_fall : slow_fall))
        else $error("tick from wrong source clock");
    a_div_four: assert property (@(posedge clk) disable iff (!arst_n)
        (in_tick[1] && st_q.div_sel[1] == 2'h1) |-> st_q.psc[1][1:0] == 2'h3)
        else $error("divide by four ticked early");

    // Pin, toggle and serial clock outputs
    a_pin_idle_high: assert property (@(posedge clk) disable iff (!arst_n)
        !st_q.toggle_out_en |=> shared_out_pin)
        else $error("pin not high with output disabled");
    a_pin_follows: assert property (@(posedge clk) disable iff (!arst_n)
        st_q.toggle_out_en |=> shared_out_pin == toggle_out)
        else $error("pin does not follow toggle");
    a_toggle_flip: assert property (@(posedge clk) disable iff (!arst_n)
        (!st_q.toggle_source_sel && uf[0]) |=> toggle_out != $past(toggle_out))
        else $error("toggle did not flip on underflow");
    a_toggle_channel: assert property (@(posedge clk) disable iff (!arst_n)
        (st_q.toggle_source_sel && !uf[1]) |=> toggle_out == $past(toggle_out))
        else $error("toggle moved without counter 1 underflow");
    a_sclk_flip: assert property (@(posedge clk) disable iff (!arst_n)
        (uf[1] && st_q.active[1]) |=> serial_clk_out != $past(serial_clk_out))
        else $error("serial clock did not flip");

endmodule : drdt_timer
`default_nettype wire

// ---- dv/drdt_src_model.sv ----
// Purpose: Far side of the timer: both oscillators and the event pulse source
// Assumes: Oscillators run free and unrelated in phase to clk
// Notes:   The bench commands the event level and the fast oscillator switch
`timescale 1ns/1ps
`default_nettype none

module drdt_src_model (
    input  wire logic fast_en,
    input  wire logic evt_lvl,
    output logic      slow_osc,
    output logic      fast_osc,
    output logic      event_in_pin
);
    logic fast_run;

    // Slow oscillator, about 16.5 clk a period so its edges drift against clk
    initial slow_osc = 1'h0;
    always #331 slow_osc = ~slow_osc;

    // Fast oscillator is off after reset and stands at 0 until switched on
    initial fast_run = 1'h0;
    always #163 fast_run = ~fast_run;
    assign fast_osc = fast_run & fast_en;

    // Push-pull event source, never released
    assign event_in_pin = evt_lvl;
endmodule : drdt_src_model
`default_nettype wire

// ---- dv/tb.sv ----
// Purpose: Self-checking bench of the dual reload down timer
// Assumes: 25 MHz clk, oscillators and event pin from drdt_src_model
// Notes:   Periods are measured in oscillator falling edges, never in clk
`timescale 1ns/1ps
`default_nettype none
`include "drdt_map.svh"

module tb;
    logic        clk;
    logic        arst_n;
    logic        cyc, stb, we, ack;
    logic [17:0] adr;
    logic [31:0] dat_w;
    logic [31:0] dat_r;
    logic        pin, tgl, sclk_o, irq0, irq1;
    logic        slow, fast, evt_pin, fast_en, evt_lvl;
    int          n_errors = 0;
    int          n_compared = 0;
    int          n_slow = 0;
    int          n_fast = 0;
    int          ratio [4] = '{1, 4, 32, 256};

    drdt_timer dut_u (.clk(clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
        .slow_osc(slow), .fast_osc(fast), .event_in_pin(evt_pin), .shared_out_pin(pin),
        .toggle_out(tgl), .serial_clk_out(sclk_o), .irq_counter0(irq0), .irq_counter1(irq1));
    drdt_src_model src_u (.fast_en(fast_en), .evt_lvl(evt_lvl), .slow_osc(slow), .fast_osc(fast),
        .event_in_pin(evt_pin));

    // Clock and the oscillator edge counters used as the measuring stick
    always #20 clk = ~clk;
    always @(negedge slow) n_slow <= n_slow + 1;
    always @(negedge fast) n_fast <= n_fast + 1;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Classic cycle; ack and data are taken at the edge that samples ack high
    task automatic xfer(input logic w, input logic [15:0] ix, input logic [3:0] d, output logic [31:0] q);
        @(posedge clk);
        cyc   <= 1'h1;
        stb   <= 1'h1;
        we    <= w;
        adr   <= {ix, 2'h0};
        dat_w <= {28'h0, d};
        // Waits as long as the slave needs; only the watchdog ends a hang
        do begin
            @(posedge clk);
        end while (ack !== 1'h1);
        chk(32'(ack), 32'h1);
        q = dat_r;
        cyc <= 1'h0;
        stb <= 1'h0;
    endtask : xfer

    task automatic wr(input logic [15:0] ix, input logic [3:0] d);
        logic [31:0] q;
        xfer(1'h1, ix, d, q);
    endtask : wr

    task automatic rd_chk(input logic [15:0] ix, input logic [3:0] e);
        logic [31:0] q;
        xfer(1'h0, ix, 4'h0, q);
        chk(q, {28'h0, e});
    endtask : rd_chk

    task automatic evt(input logic v, input int n);
        @(posedge clk);
        evt_lvl <= v;
        repeat (n) @(posedge clk);
    endtask : evt

    task automatic pulses(input int n);
        repeat (n) begin
            evt(1'h1, 10);
            evt(1'h0, 10);
        end
    endtask : pulses

    // Waits for one change of toggle_out or serial_clk_out, bounded
    task automatic flip(input logic s);
        logic v;
        int   k;
        v = s ? sclk_o : tgl;
        for (k = 0; k < 20000 && (s ? sclk_o : tgl) === v; k++) @(posedge clk);
        if (k == 20000) chk(32'h0, 32'h1);
    endtask : flip

    // First two changes may straddle a reconfiguration, so they are skipped
    task automatic meas(input logic s, input logic f, input int exp);
        int n0;
        flip(s);
        flip(s);
        n0 = f ? n_fast : n_slow;
        flip(s);
        chk((f ? n_fast : n_slow) - n0, exp);
    endtask : meas

    task automatic t_regs();
        chk({28'h0, pin, tgl, irq0, irq1}, 32'h8);
        for (int i = 0; i < 12; i++) rd_chk(16'(`DRDT_IX_EVCFG + i), 4'h0);
        rd_chk(`DRDT_IX_MASK, 4'h0);
        rd_chk(`DRDT_IX_FLAGS, 4'h0);
        wr(`DRDT_IX_EVCFG, 4'hf);
        rd_chk(`DRDT_IX_EVCFG, 4'h7);
        wr(`DRDT_IX_OUTSEL, 4'hf);
        rd_chk(`DRDT_IX_OUTSEL, 4'hf);
        wr(`DRDT_IX_MASK, 4'hf);
        rd_chk(`DRDT_IX_MASK, 4'h3);
        wr(`DRDT_IX_CTRL1, 4'he);
        rd_chk(`DRDT_IX_CTRL1, 4'hc);
        wr(`DRDT_IX_RLD1_HI, 4'ha);
        rd_chk(`DRDT_IX_RLD1_HI, 4'ha);
        wr(`DRDT_IX_CNT0_LO, 4'hf);
        rd_chk(`DRDT_IX_CNT0_LO, 4'h0);
        wr(`DRDT_IX_FLAGS, 4'hf);
        rd_chk(`DRDT_IX_FLAGS, 4'h0);
        wr(16'hffd0, 4'hf);
        rd_chk(16'hffd0, 4'h0);
        wr(`DRDT_IX_OUTSEL, 4'h0);
        wr(`DRDT_IX_MASK, 4'h0);
        wr(`DRDT_IX_CTRL1, 4'h0);
        wr(`DRDT_IX_RLD1_HI, 4'h0);
    endtask : t_regs

    // Event counting; ratio field left at 256 must not matter
    task automatic t_event();
        wr(`DRDT_IX_RLD0_HI, 4'h1);
        wr(`DRDT_IX_EVCFG, 4'h4);
        wr(`DRDT_IX_CTRL0, 4'hf);
        rd_chk(`DRDT_IX_CTRL0, 4'hd);
        pulses(1);
        rd_chk(`DRDT_IX_CNT0_LO, 4'h0);
        pulses(1);
        rd_chk(`DRDT_IX_CNT0_HI, 4'h1);
        rd_chk(`DRDT_IX_CNT0_LO, 4'hf);
        evt(1'h1, 10);
        rd_chk(`DRDT_IX_CNT0_LO, 4'hf);
        evt(1'h0, 10);
        rd_chk(`DRDT_IX_CNT0_LO, 4'he);
        wr(`DRDT_IX_EVCFG, 4'h5);
        evt(1'h1, 10);
        rd_chk(`DRDT_IX_CNT0_LO, 4'hd);
        evt(1'h0, 10);
        rd_chk(`DRDT_IX_CNT0_LO, 4'hd);
        wr(`DRDT_IX_CTRL0, 4'hc);
        rd_chk(`DRDT_IX_CTRL0, 4'hd);
        evt(1'h1, 10);
        rd_chk(`DRDT_IX_CTRL0, 4'hc);
        rd_chk(`DRDT_IX_CNT0_LO, 4'hc);
        pulses(1);
        evt(1'h1, 900);
        rd_chk(`DRDT_IX_CNT0_LO, 4'hc);
        wr(`DRDT_IX_EVCFG, 4'h7);
        wr(`DRDT_IX_CTRL0, 4'hd);
        evt(1'h0, 900);
        evt(1'h1, 900);
        evt(1'h0, 100);
        evt(1'h1, 900);
        rd_chk(`DRDT_IX_CNT0_LO, 4'hc);
        evt(1'h0, 900);
        evt(1'h1, 900);
        rd_chk(`DRDT_IX_CNT0_LO, 4'hb);
    endtask : t_event

    task automatic t_irq();
        wr(`DRDT_IX_EVCFG, 4'h4);
        wr(`DRDT_IX_RLD0_LO, 4'h1);
        wr(`DRDT_IX_RLD0_HI, 4'h0);
        wr(`DRDT_IX_CTRL0, 4'h3);
        evt(1'h0, 10);
        pulses(2);
        rd_chk(`DRDT_IX_CNT0_LO, 4'h0);
        chk({29'h0, tgl, pin, irq0}, 32'h6);
        rd_chk(`DRDT_IX_FLAGS, 4'h1);
        wr(`DRDT_IX_FLAGS, 4'h0);
        rd_chk(`DRDT_IX_FLAGS, 4'h1);
        wr(`DRDT_IX_MASK, 4'h1);
        repeat (3) @(posedge clk);
        chk(32'(irq0), 32'h1);
        wr(`DRDT_IX_FLAGS, 4'h1);
        repeat (3) @(posedge clk);
        chk(32'(irq0), 32'h0);
        rd_chk(`DRDT_IX_FLAGS, 4'h0);
        wr(`DRDT_IX_OUTSEL, 4'h8);
        pulses(2);
        chk(32'(tgl), 32'h1);
        wr(`DRDT_IX_OUTSEL, 4'h4);
        pulses(2);
        chk({30'h0, tgl, pin}, 32'h0);
        wr(`DRDT_IX_CTRL0, 4'h0);
        pulses(1);
        wr(`DRDT_IX_MASK, 4'h0);
    endtask : t_irq

    // Reload 1 gives two ticks per underflow, reload 2 gives three
    task automatic t_timer();
        wr(`DRDT_IX_EVCFG, 4'h0);
        wr(`DRDT_IX_OUTSEL, 4'h0);
        for (int d = 0; d < 4; d++) begin
            wr(`DRDT_IX_CTRL0, {d[1:0], 2'h3});
            meas(1'h0, 1'h0, 2 * ratio[d]);
        end
        wr(`DRDT_IX_CTRL0, 4'h0);
        fast_en <= 1'h1;
        repeat (50) @(posedge clk);
        wr(`DRDT_IX_OUTSEL, 4'ha);
        wr(`DRDT_IX_RLD1_LO, 4'h2);
        wr(`DRDT_IX_CTRL1, 4'h7);
        meas(1'h0, 1'h1, 12);
        meas(1'h1, 1'h1, 12);
        wr(`DRDT_IX_MASK, 4'h2);
        repeat (3) @(posedge clk);
        chk(32'(irq1), 32'h1);
        rd_chk(`DRDT_IX_FLAGS, 4'h3);
        wr(`DRDT_IX_MASK, 4'h0);
        wr(`DRDT_IX_CTRL1, 4'h0);
    endtask : t_timer

    task automatic wrap_up();
        if (n_errors == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : wrap_up

    // Main sequence
    initial begin
        clk = 1'h0;
        arst_n = 1'h0;
        cyc = 1'h0;
        stb = 1'h0;
        we = 1'h0;
        adr = 18'h0;
        dat_w = 32'h0;
        fast_en = 1'h0;
        evt_lvl = 1'h0;
        repeat (4) @(posedge clk);
        arst_n <= 1'h1;
        t_regs();
        t_event();
        t_irq();
        t_timer();
        wrap_up();
    end

    // Watchdog, well above the expected 40k cycles
    initial begin
        repeat (90000) @(posedge clk);
        chk(32'h0, 32'h1);
        wrap_up();
    end
endmodule : tb
`default_nettype wire
